/* stp_cfg.svh */
// Register map, field positions, reset values and widths of the shared timer prescaler
`ifndef STP_CFG_SVH
`define STP_CFG_SVH

`define STP_ADDR_GTC    4'h0
`define STP_ADDR_CS0    4'h1
`define STP_ADDR_PRE_LO 4'h8
`define STP_ADDR_PRE_HI 4'h9

`define STP_BIT_HOLD    7
`define STP_BIT_ASY     1
`define STP_BIT_SYNC    0

`define STP_RST_GTC     8'h00
`define STP_RST_CS      3'h0
`define STP_RST_PRE     10'h000

`define STP_PRE_W       10
`define STP_TAP_8       3
`define STP_TAP_64      6
`define STP_TAP_256     8
`define STP_TAP_1024    10

`endif

/* stp_pkg.sv */
// Types shared by the shared timer prescaler modules
package stp_pkg;

    // Clock source select codes, values 0 to 7 in this order
    typedef enum logic [2:0] {
        STP_CS_STOP,
        STP_CS_DIRECT,
        STP_CS_DIV8,
        STP_CS_DIV64,
        STP_CS_DIV256,
        STP_CS_DIV1024,
        STP_CS_EXT_FALL,
        STP_CS_EXT_RISE
    } stp_cs_t;

    typedef logic [3:0] stp_addr_t;
    typedef logic [7:0] stp_byte_t;

endpackage : stp_pkg

/* stp_src_if.sv */
// Tick sources handed to one timer's clock selector
`timescale 1ns/1ps
`default_nettype none
interface stp_src_if;
    import stp_pkg::*;

    stp_cs_t    cs;        // Selected source
    logic [3:0] taps;      // Prescaler taps, /8 up to /1024
    logic       halt;      // Prescaler reset holds the timer
    logic       ext_rise;  // Pin rising edge seen
    logic       ext_fall;  // Pin falling edge seen

    modport sync (output ext_rise, output ext_fall);
    modport sel  (input cs, input taps, input halt, input ext_rise, input ext_fall);
endinterface : stp_src_if
`default_nettype wire

/* stp_pin_sync.sv */
// Synchroniser and edge detector for one external count pin
`timescale 1ns/1ps
`default_nettype none
module stp_pin_sync (
    input  wire logic ref_clk,  // System clock
    input  wire logic rstn,     // Async reset, active low
    input  wire logic pin,      // External count pin
    stp_src_if.sync   src       // Edge pulses
);
    logic lat_q;
    logic sync1_ff;
    logic sync2_ff;
    logic prev_ff;

    // Front latch, transparent in the high clock phase
    always_latch begin
        if (ref_clk) begin
            lat_q <= pin;
        end
    end

    // Three rising-edge flops, sampled once per cycle
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            sync1_ff <= 1'b0;
            sync2_ff <= 1'b0;
            prev_ff  <= 1'b0;
        end else begin
            sync1_ff <= lat_q;
            sync2_ff <= sync1_ff;
            prev_ff  <= sync2_ff;
        end
    end

    // Edge detector on the synchronised level
    assign src.ext_rise = sync2_ff & ~prev_ff;
    assign src.ext_fall = ~sync2_ff & prev_ff;
endmodule : stp_pin_sync
`default_nettype wire

/* stp_clk_sel.sv */
// Clock source selector and tick register for one timer
`timescale 1ns/1ps
`default_nettype none
module stp_clk_sel (
    input  wire logic ref_clk,  // System clock
    input  wire logic rstn,     // Async reset, active low
    stp_src_if.sel    src,      // Available tick sources
    output var  logic tick_ff   // Timer count tick
);
    import stp_pkg::*;

    logic nxt_tick;

    // Pick the source named by the select code
    always_comb begin
        case (src.cs)
            STP_CS_STOP:     nxt_tick = 1'b0;
            STP_CS_DIRECT:   nxt_tick = 1'b1;
            STP_CS_DIV8:     nxt_tick = src.taps[0];
            STP_CS_DIV64:    nxt_tick = src.taps[1];
            STP_CS_DIV256:   nxt_tick = src.taps[2];
            STP_CS_DIV1024:  nxt_tick = src.taps[3];
            STP_CS_EXT_FALL: nxt_tick = src.ext_fall;
            STP_CS_EXT_RISE: nxt_tick = src.ext_rise;
            default:         nxt_tick = 1'b0;
        endcase
        if (src.halt) begin
            nxt_tick = 1'b0;
        end
    end

    // Registered tick
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            tick_ff <= 1'b0;
        end else begin
            tick_ff <= nxt_tick;
        end
    end
endmodule : stp_clk_sel
`default_nettype wire

/* stp_top.sv */
// Shared prescaler, clock selection and control register for the synchronous timers
//
// Local design decisions: the register offsets and the address-and-strobe port.
`include "stp_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module stp_top #(
    parameter int NUM_TIMERS = 5  // Timers sharing the prescaler
) (
    input  wire logic                  ref_clk,                // System clock, 10 MHz
    input  wire logic                  rstn,                   // Async reset, active low
    input  wire stp_pkg::stp_addr_t    addr,                   // Register address
    input  wire stp_pkg::stp_byte_t    wr_data,                // Write data
    input  wire logic                  wr_stb,                 // Write strobe
    input  wire logic                  rd_stb,                 // Read strobe
    output var  stp_pkg::stp_byte_t    rd_data,                // Read data, cycle after strobe
    input  wire logic [NUM_TIMERS-1:0] external_count_pin,     // External count pins
    output wire logic [NUM_TIMERS-1:0] timer_count_tick,       // Per-timer count ticks
    output var  logic                  async_prescaler_reset   // Reset to the async prescaler
);
    import stp_pkg::*;

    // Reset image of the control register
    localparam stp_byte_t GTC_RST = `STP_RST_GTC;

    // Control bits
    logic hold_ff;
    logic sync_ff;
    logic nxt_hold;
    logic nxt_sync;
    logic nxt_asy;

    // Free-running prescaler
    logic [`STP_PRE_W-1:0] pre_ff;
    logic [3:0]            taps;

    // Per-timer select codes
    stp_cs_t cs_ff [NUM_TIMERS];

    // Bus decode
    logic      gtc_wr;
    stp_byte_t nxt_rd;

    assign gtc_wr = wr_stb && (addr == `STP_ADDR_GTC);

    // Control register next state
    // A write wins over the hardware clear
    always_comb begin
        nxt_hold = hold_ff;
        nxt_sync = sync_ff;
        nxt_asy  = async_prescaler_reset;
        if (!hold_ff) begin
            nxt_sync = 1'b0;
            nxt_asy  = 1'b0;
        end
        if (gtc_wr) begin
            nxt_hold = wr_data[`STP_BIT_HOLD];
            nxt_sync = wr_data[`STP_BIT_SYNC];
            nxt_asy  = wr_data[`STP_BIT_ASY];
        end
    end

    // Control register, reset bits kept while hold is set
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            hold_ff               <= GTC_RST[`STP_BIT_HOLD];
            sync_ff               <= GTC_RST[`STP_BIT_SYNC];
            async_prescaler_reset <= GTC_RST[`STP_BIT_ASY];
        end else begin
            hold_ff               <= nxt_hold;
            sync_ff               <= nxt_sync;
            async_prescaler_reset <= nxt_asy;
        end
    end

    // Prescaler counts every cycle the sync reset bit is clear, regardless of any select
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            pre_ff <= `STP_RST_PRE;
        end else if (sync_ff) begin
            pre_ff <= `STP_RST_PRE;
        end else begin
            pre_ff <= pre_ff + 1'b1;
        end
    end

    // Tap strobes, one cycle in every N, so a new select waits at most N
    assign taps[0] = &pre_ff[`STP_TAP_8-1:0];
    assign taps[1] = &pre_ff[`STP_TAP_64-1:0];
    assign taps[2] = &pre_ff[`STP_TAP_256-1:0];
    assign taps[3] = &pre_ff[`STP_TAP_1024-1:0];

    // One select register, synchroniser and selector per timer
    for (genvar gi = 0; gi < NUM_TIMERS; gi++) begin : g_tmr
        stp_src_if src ();

        // Select register of this timer only
        always_ff @(posedge ref_clk or negedge rstn) begin
            if (!rstn) begin
                cs_ff[gi] <= stp_cs_t'(`STP_RST_CS);
            end else if (wr_stb && (addr == 4'(`STP_ADDR_CS0 + gi))) begin
                cs_ff[gi] <= stp_cs_t'(wr_data[2:0]);
            end
        end

        // Shared taps and halt
        assign src.cs   = cs_ff[gi];
        assign src.taps = taps;
        assign src.halt = sync_ff;

        stp_pin_sync u_sync (
            .ref_clk (ref_clk),
            .rstn    (rstn),
            .pin     (external_count_pin[gi]),
            .src     (src)
        );

        stp_clk_sel u_sel (
            .ref_clk (ref_clk),
            .rstn    (rstn),
            .src     (src),
            .tick_ff (timer_count_tick[gi])
        );

        // Per-timer checks, so that every select and pin of the group is watched
        // Stopped timer stays quiet
        a_tmr_stop_quiet: assert property (
            @(posedge ref_clk) disable iff (!rstn)
            (cs_ff[gi] == STP_CS_STOP) |=> !timer_count_tick[gi])
            else $error("stopped timer ticked");

        // Direct source ticks every cycle unless halted
        a_tmr_direct: assert property (
            @(posedge ref_clk) disable iff (!rstn)
            (cs_ff[gi] == STP_CS_DIRECT && !sync_ff) |=> timer_count_tick[gi])
            else $error("direct source missed a tick");

        // Rising pin edge ticks the timer two or three cycles later
        a_tmr_rise_tick: assert property (
            @(posedge ref_clk) disable iff (!rstn)
            ($rose(external_count_pin[gi]) ##0 (cs_ff[gi] == STP_CS_EXT_RISE && !sync_ff) [*4])
            |-> (timer_count_tick[gi] || $past(timer_count_tick[gi])))
            else $error("pin rising edge missed");

        // Falling pin edge ticks the timer two or three cycles later
        a_tmr_fall_tick: assert property (
            @(posedge ref_clk) disable iff (!rstn)
            ($fell(external_count_pin[gi]) ##0 (cs_ff[gi] == STP_CS_EXT_FALL && !sync_ff) [*4])
            |-> (timer_count_tick[gi] || $past(timer_count_tick[gi])))
            else $error("pin falling edge missed");

        // A still pin never ticks, whatever the prescaler does
        a_tmr_ext_quiet: assert property (
            @(posedge ref_clk) disable iff (!rstn)
            ((cs_ff[gi] == STP_CS_EXT_RISE || cs_ff[gi] == STP_CS_EXT_FALL) && !sync_ff
             && $stable(external_count_pin[gi])) [*4]
            |-> !timer_count_tick[gi])
            else $error("still pin gave a tick");
    end

    // Read multiplexer, unmapped addresses read zero
    always_comb begin
        nxt_rd = 8'h00;
        if (rd_stb) begin
            if (addr == `STP_ADDR_GTC) begin
                nxt_rd[`STP_BIT_HOLD] = hold_ff;
                nxt_rd[`STP_BIT_ASY]  = async_prescaler_reset;
                nxt_rd[`STP_BIT_SYNC] = sync_ff;
            end else if (addr == `STP_ADDR_PRE_LO) begin
                nxt_rd = pre_ff[7:0];
            end else if (addr == `STP_ADDR_PRE_HI) begin
                nxt_rd = {6'h00, pre_ff[9:8]};
            end
            for (int i = 0; i < NUM_TIMERS; i++) begin
                if (addr == 4'(`STP_ADDR_CS0 + i)) begin
                    nxt_rd = {5'h00, cs_ff[i]};
                end
            end
        end
    end

    // Read data stand for one cycle only
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rd_data <= 8'h00;
        end else begin
            rd_data <= nxt_rd;
        end
    end

    // Checks on timer 0 and the shared state
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rstn);

    stp_cs_t cs0;
    logic    tick0;
    logic    pin0;
    logic    rise_ok;
    logic    fall_ok;

    assign cs0     = cs_ff[0];
    assign tick0   = timer_count_tick[0];
    assign pin0    = external_count_pin[0];
    assign rise_ok = (cs0 == STP_CS_EXT_RISE) && !sync_ff;
    assign fall_ok = (cs0 == STP_CS_EXT_FALL) && !sync_ff;

    // Direct source ticks every cycle
    a_direct_every_cycle: assert property (
        (cs0 == STP_CS_DIRECT && !sync_ff) |=> tick0)
        else $error("direct source missed a tick");

    // Stopped timer never ticks
    a_stop_no_tick: assert property (
        (cs0 == STP_CS_STOP) |=> !tick0)
        else $error("stopped timer ticked");

    // Divide by 8 ticks only when the low bits are all ones
    a_div8_tick: assert property (
        (cs0 == STP_CS_DIV8 && !sync_ff) |=> (tick0 == $past(&pre_ff[2:0])))
        else $error("div8 tick at wrong count");

    // Divide by 1024 ticks only at the top count
    a_div1024_tick: assert property (
        (cs0 == STP_CS_DIV1024 && !sync_ff) |=> (tick0 == $past(&pre_ff)))
        else $error("div1024 tick at wrong count");

    // Prescaler steps by one while the sync reset bit is clear; the reset release edge is skipped
    a_pre_free_run: assert property (
        (rstn && !sync_ff) |=> (pre_ff == 10'($past(pre_ff) + 10'h001)))
        else $error("prescaler did not advance");

    // Reset bit clears the prescaler and stops ticks
    a_pre_reset_all: assert property (
        sync_ff |=> (pre_ff == 10'h000) && !tick0)
        else $error("prescaler reset not applied");

    // Without hold the reset bit lasts one cycle
    a_sync_self_clear: assert property (
        (sync_ff && !hold_ff && !gtc_wr) |=> !sync_ff)
        else $error("sync reset bit did not clear");

    // With hold the reset bits stay set
    a_hold_keeps_bits: assert property (
        (hold_ff && sync_ff && async_prescaler_reset && !gtc_wr)
        |=> sync_ff && async_prescaler_reset)
        else $error("hold mode lost a reset bit");

    // Writing hold low releases both bits within two cycles
    a_hold_release: assert property (
        (gtc_wr && !wr_data[`STP_BIT_HOLD]) |-> ##2 (!sync_ff && !async_prescaler_reset))
        else $error("reset bits not released");

    // First prescaled count after enable within the divisor
    a_first_count: assert property (
        (cs0 == STP_CS_STOP ##1 (cs0 == STP_CS_DIV8 && !sync_ff && !gtc_wr))
        |-> ##[1:8] tick0)
        else $error("first div8 count late");

    // Rising pin edge gives a tick two or three cycles later
    sequence s_pin_rise;
        $rose(pin0) ##0 rise_ok [*4];
    endsequence
    a_ext_rise_tick: assert property (
        s_pin_rise |-> (tick0 || $past(tick0)))
        else $error("pin rising edge lost");

    // Falling pin edge gives a tick two or three cycles later
    sequence s_pin_fall;
        $fell(pin0) ##0 fall_ok [*4];
    endsequence
    a_ext_fall_tick: assert property (
        s_pin_fall |-> (tick0 || $past(tick0)))
        else $error("pin falling edge lost");

    // A quiet pin gives no tick, whatever the prescaler does
    a_ext_no_prescale: assert property (
        (rise_ok && $stable(pin0)) [*4] |-> !tick0)
        else $error("pin source ticked without edge");

    // Divide by 64 ticks only when the low six bits are all ones
    a_div64_tick: assert property (
        (cs0 == STP_CS_DIV64 && !sync_ff) |=> (tick0 == $past(&pre_ff[5:0])))
        else $error("div64 tick at wrong count");

    // Divide by 256 ticks only when the low byte is all ones
    a_div256_tick: assert property (
        (cs0 == STP_CS_DIV256 && !sync_ff) |=> (tick0 == $past(&pre_ff[7:0])))
        else $error("div256 tick at wrong count");

    // Prescaler reset halts every timer, not only timer 0
    a_halt_all_ticks: assert property (
        sync_ff |=> (timer_count_tick == '0))
        else $error("a timer ticked during prescaler reset");

    // Without hold the async reset bit also lasts one cycle
    a_async_self_clear: assert property (
        (async_prescaler_reset && !hold_ff && !gtc_wr) |=> !async_prescaler_reset)
        else $error("async reset bit did not clear");

    // A control write sets the sync reset bit at once
    a_sync_write_sets: assert property (
        (gtc_wr && wr_data[`STP_BIT_SYNC]) |=> sync_ff)
        else $error("sync reset bit not stored");

    // A control write stores the hold mode bit
    a_hold_write: assert property (
        gtc_wr |=> (hold_ff == $past(wr_data[`STP_BIT_HOLD])))
        else $error("hold mode bit not stored");

    // A select write lands in the register of timer 0
    a_sel_write: assert property (
        (wr_stb && addr == `STP_ADDR_CS0) |=> (cs0 == stp_cs_t'($past(wr_data[2:0]))))
        else $error("select write lost");

    // Read data fall back to zero after a cycle without a read
    a_rd_idle_zero: assert property (
        !rd_stb |=> (rd_data == 8'h00))
        else $error("read data stood too long");

    // Control read returns hold, async and sync bits, others zero
    a_rd_ctrl_bits: assert property (
        (rd_stb && addr == `STP_ADDR_GTC)
        |=> (rd_data == {$past(hold_ff), 5'h00, $past(async_prescaler_reset), $past(sync_ff)}))
        else $error("control read wrong");

    // Select read returns the stored code of timer 0
    a_rd_sel_value: assert property (
        (rd_stb && addr == `STP_ADDR_CS0) |=> (rd_data == {5'h00, $past(cs0)}))
        else $error("select read wrong");

    // Prescaler low read returns the running count
    a_rd_pre_lo: assert property (
        (rd_stb && addr == `STP_ADDR_PRE_LO) |=> (rd_data == $past(pre_ff[7:0])))
        else $error("prescaler low read wrong");

    // Prescaler high read returns the top two bits only
    a_rd_pre_hi: assert property (
        (rd_stb && addr == `STP_ADDR_PRE_HI) |=> (rd_data == {6'h00, $past(pre_ff[9:8])}))
        else $error("prescaler high read wrong");

    // Scenarios of interest
    c_direct_run: cover property (
        (cs0 == STP_CS_DIRECT) ##1 tick0 [*3]);

    c_hold_release: cover property (
        hold_ff && sync_ff ##1 !hold_ff ##[1:2] !sync_ff);

    c_ext_tick: cover property (
        rise_ok ##1 tick0);

    c_div1024_tick: cover property (
        (cs0 == STP_CS_DIV1024) ##1 tick0);

endmodule : stp_top
`default_nettype wire

/* stp_pin_src.sv */
// Model of the external clock source on the timer count pins
`timescale 1ns/1ps
`default_nettype none
module stp_pin_src #(
    parameter int HALF = 5  // Cycles per phase, kept above one
) (
    input  wire logic ref_clk,  // System clock
    input  wire logic rstn,     // Async reset, active low
    input  wire logic run,      // Toggle the pin while high
    output var  logic pin_ff    // External count pin level
);
    int cnt_ff;

    // Toggle every HALF cycles, hold the pin still while stopped
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            cnt_ff <= 0;
            pin_ff <= 1'b0;
        end else if (!run) begin
            cnt_ff <= 0;
        end else if (cnt_ff == HALF - 1) begin
            cnt_ff <= 0;
            pin_ff <= ~pin_ff;
        end else begin
            cnt_ff <= cnt_ff + 1;
        end
    end
endmodule : stp_pin_src
`default_nettype wire

/* shared_timer_prescaler_tb.sv */
// Self-checking testbench for the shared timer prescaler
`include "stp_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module shared_timer_prescaler_tb;
    import stp_pkg::*;
    logic       ref_clk;
    logic       rstn;
    stp_addr_t  addr;
    stp_byte_t  wr_data;
    logic       wr_stb;
    logic       rd_stb;
    stp_byte_t  rd_data;
    logic [4:0] tick;
    logic       asy;
    logic       run;
    logic       pin;
    stp_byte_t  rv;
    int         mismatches;
    int         checks_done;

    stp_top #(.NUM_TIMERS(5)) uut (.ref_clk(ref_clk), .rstn(rstn), .addr(addr), .wr_data(wr_data),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data), .external_count_pin({5{pin}}),
        .timer_count_tick(tick), .async_prescaler_reset(asy));
    stp_pin_src #(.HALF(5)) src (.ref_clk(ref_clk), .rstn(rstn), .run(run), .pin_ff(pin));

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : chk

    task automatic wr(input stp_addr_t a, input stp_byte_t d);
        @(posedge ref_clk);
        addr    <= a;
        wr_data <= d;
        wr_stb  <= 1'b1;
        @(posedge ref_clk);
        wr_stb  <= 1'b0;
    endtask : wr

    // Read data stands only in the cycle after the strobe edge
    task automatic rd(input stp_addr_t a);
        @(posedge ref_clk);
        addr   <= a;
        rd_stb <= 1'b1;
        @(posedge ref_clk);
        rd_stb <= 1'b0;
        #1;
        rv = rd_data;
    endtask : rd

    task automatic cnt(input int b, input int n, output int c);
        c = 0;
        repeat (n) begin
            @(posedge ref_clk);
            #1;
            if (tick[b] === 1'b1) c++;
        end
    endtask : cnt

    // Cycles until the first tick of timer b, bounded by lim
    task automatic first(input int b, input int lim, output int c);
        c = 0;
        do begin
            @(posedge ref_clk);
            #1;
            c++;
        end while (tick[b] !== 1'b1 && c < lim);
    endtask : first

    task automatic t_reset();
        rd(`STP_ADDR_GTC);
        chk("control", rv, 8'h00);
        rd(`STP_ADDR_CS0);
        chk("select0", rv, 8'h00);
        rd(4'h6);
        chk("unmapped", rv, 8'h00);
        chk("ticks", tick, 5'h00);
        chk("async out", asy, 1'b0);
    endtask : t_reset

    task automatic t_direct();
        int c;
        wr(`STP_ADDR_CS0, 8'h01);
        @(posedge ref_clk);
        cnt(0, 20, c);
        chk("direct ticks", c, 20);
        wr(`STP_ADDR_CS0, 8'h00);
        repeat (2) @(posedge ref_clk);
        cnt(0, 20, c);
        chk("stopped ticks", c, 0);
    endtask : t_direct

    task automatic t_taps();
        int        c;
        int        div[4] = '{8, 64, 256, 1024};
        stp_byte_t v1;
        for (int k = 0; k < 4; k++) begin
            wr(`STP_ADDR_CS0, 8'(k + 2));
            first(0, div[k] + 2, c);
            chk("first tick", c <= div[k] + 1, 1);
            cnt(0, 2 * div[k], c);
            chk("tap ticks", c, 2);
        end
        // Changing a select must not disturb the running prescaler
        rd(`STP_ADDR_PRE_LO);
        v1 = rv;
        wr(`STP_ADDR_CS0, 8'h02);
        rd(`STP_ADDR_PRE_LO);
        chk("free run", 8'(rv - v1), 8'h04);
        rd(`STP_ADDR_PRE_HI);
        chk("prescaler high", rv[7:2], 6'h00);
        wr(`STP_ADDR_CS0, 8'h00);
    endtask : t_taps

    task automatic t_shared();
        int c;
        int c2;
        wr(`STP_ADDR_CS0, 8'h02);
        wr(`STP_ADDR_CS0 + 4'h1, 8'h03);
        cnt(0, 128, c);
        chk("timer0 /8", c, 16);
        cnt(1, 128, c);
        chk("timer1 /64", c, 2);
        wr(`STP_ADDR_GTC, 8'h01);
        first(0, 20, c);
        chk("timer0 restart", c >= 8 && c <= 10, 1);
        first(1, 70, c2);
        chk("timer1 restart", c + c2 >= 64 && c + c2 <= 66, 1);
        wr(`STP_ADDR_CS0, 8'h00);
        wr(`STP_ADDR_CS0 + 4'h1, 8'h00);
    endtask : t_shared

    task automatic t_hold();
        int c;
        wr(`STP_ADDR_GTC, 8'h03);
        rd(`STP_ADDR_GTC);
        chk("sync self clear", rv, 8'h00);
        wr(`STP_ADDR_CS0, 8'h01);
        wr(`STP_ADDR_CS0 + 4'h1, 8'h01);
        wr(`STP_ADDR_GTC, 8'h83);
        rd(`STP_ADDR_GTC);
        chk("held bits", rv, 8'h83);
        @(posedge ref_clk);
        #1;
        chk("read idle", rd_data, 8'h00);
        chk("async held", asy, 1'b1);
        cnt(0, 20, c);
        chk("halted", c, 0);
        wr(`STP_ADDR_GTC, 8'h00);
        first(0, 5, c);
        chk("same start", tick[1:0], 2'b11);
        rd(`STP_ADDR_GTC);
        chk("released bits", rv, 8'h00);
        wr(`STP_ADDR_CS0, 8'h00);
        wr(`STP_ADDR_CS0 + 4'h1, 8'h00);
    endtask : t_hold

    task automatic t_ext();
        int c;
        wr(`STP_ADDR_CS0, 8'h07);
        wr(`STP_ADDR_CS0 + 4'h1, 8'h06);
        run <= 1'b1;
        do begin
            @(posedge ref_clk);
            #1;
        end while (pin !== 1'b1);
        first(0, 6, c);
        chk("pin latency", c >= 2 && c <= 3, 1);
        cnt(0, 100, c);
        chk("rising ticks", c, 10);
        cnt(1, 100, c);
        chk("falling ticks", c, 10);
        @(posedge ref_clk);
        run <= 1'b0;
    endtask : t_ext

    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : stop_test

    // Clock generator
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    // Main sequence
    initial begin
        rstn        = 1'b0;
        addr        = '0;
        wr_data     = '0;
        wr_stb      = 1'b0;
        rd_stb      = 1'b0;
        run         = 1'b0;
        mismatches  = 0;
        checks_done = 0;
        repeat (20) @(posedge ref_clk);
        rstn <= 1'b1;
        t_reset();
        t_direct();
        t_taps();
        t_shared();
        t_hold();
        t_ext();
        stop_test();
    end

    // Watchdog, well beyond the expected run length
    initial begin
        repeat (20000) @(posedge ref_clk);
        mismatches++;
        stop_test();
    end
endmodule : shared_timer_prescaler_tb
`default_nettype wire
